// ===== src/rdt_pkg.sv
// Constants, state codes and carrier types for the RTC rate-trim block.
// Assumes a single clock domain; all users reference items as rdt_pkg::name.
`default_nettype none
package rdt_pkg;
    // Divider counts of oscillator ticks per nominal 1 Hz period and per half period
    localparam logic [15:0] NOM_PERIOD = 16'h8000;
    localparam logic [15:0] HALF_PERIOD = 16'h4000;
    // Periods per trim group
    localparam logic [5:0] GROUP_COARSE = 6'h14;
    localparam logic [5:0] GROUP_FINE = 6'h3C;
    // Step code boundaries
    localparam logic [6:0] CODE_SPLIT = 7'h40;
    localparam logic [7:0] CODE_WRAP = 8'h80;
    // Register reset value and serial framing
    localparam logic [7:0] TRIM_RESET = 8'h00;
    localparam logic [2:0] BIT_LAST = 3'h7;
    localparam logic [2:0] TRIM_CMD = 3'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_ACKA = 3'b010,
        ST_WDATA = 3'b011,
        ST_ACKW = 3'b100,
        ST_RDATA = 3'b101,
        ST_RACK = 3'b110,
        ST_RNEXT = 3'b111
    } rdt_state_e;

    // Serial line events, one cycle each, plus the synchronised data level
    typedef struct packed {
        logic start;
        logic stop;
        logic rise;
        logic fall;
        logic sda;
    } rdt_bus_ev_s;
endpackage : rdt_pkg
`default_nettype wire

// ===== src/rdt_sync.sv
// Two-flop synchroniser for a group of asynchronous pin inputs.
// Assumes the inputs are independent levels; no bus coherence is implied.
`timescale 1ns/1ns
`default_nettype none
module rdt_sync #(
    parameter int W = 1
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] hold_r;

    // First stage feeds only the second
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            meta_r <= '0;
            hold_r <= '0;
        end else begin
            meta_r <= d;
            hold_r <= meta_r;
        end
    end

    assign q = hold_r;
endmodule : rdt_sync
`default_nettype wire

// ===== src/rdt_trim.sv
// Rate-trim timebase with its serial register port for an RTC.
// Assumes scl_in, sda_in and osc_in are asynchronous pins; sda is open drain.
`timescale 1ns/1ns
`default_nettype none
module rdt_trim #(
    parameter logic [3:0] DEV_CODE = 4'h5 // Arbitrary device code value
) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic osc_in,
    output logic sda_out,
    output logic sda_oe,
    output logic clk32_out,
    output logic sec_tick,
    output logic hz1_out
);
    logic [2:0] s_q;
    logic [2:0] d_r;
    rdt_pkg::rdt_bus_ev_s ev;
    logic osc_rise;

    rdt_sync #(.W(3)) rdt_sync_i (
        .clock(clock),
        .arst_n(arst_n),
        .d({scl_in, sda_in, osc_in}),
        .q(s_q)
    );

    // Delayed copy of synchronised pins for edge detection
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            d_r <= 3'h0;
        end else begin
            d_r <= s_q;
        end
    end

    // Line events from synchronised levels
    always_comb begin
        ev.start = d_r[2] & s_q[2] & d_r[1] & ~s_q[1];
        ev.stop = d_r[2] & s_q[2] & ~d_r[1] & s_q[1];
        ev.rise = s_q[2] & ~d_r[2];
        ev.fall = ~s_q[2] & d_r[2];
        ev.sda = s_q[1];
    end
    assign osc_rise = s_q[0] & ~d_r[0];

    // Period length for a trim value
    function automatic logic [15:0] trim_len(input logic [7:0] t);
        logic [6:0] c;
        c = '0;
        for (int i = 0; i < 7; i++) begin
            c[i] = t[7-i];
        end
        if (c == 7'h00) begin
            trim_len = rdt_pkg::NOM_PERIOD;
        end else if (c < rdt_pkg::CODE_SPLIT) begin
            trim_len = rdt_pkg::NOM_PERIOD - {8'h00, c, 1'b0};
        end else begin
            trim_len = rdt_pkg::NOM_PERIOD + {7'h00, rdt_pkg::CODE_WRAP - {1'b0, c}, 1'b0};
        end
    endfunction : trim_len

    // Serial port state
    rdt_pkg::rdt_state_e st_r, st_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic oe_r, oe_nxt;
    logic [7:0] trim_r, trim_nxt;
    logic [7:0] byte_in;

    // Byte framing, acknowledge and register access
    always_comb begin
        st_nxt = st_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        oe_nxt = oe_r;
        trim_nxt = trim_r;
        byte_in = {sh_r[6:0], ev.sda};
        if (ev.stop) begin
            st_nxt = rdt_pkg::ST_IDLE;
            oe_nxt = 1'b0;
        end else if (ev.start) begin
            st_nxt = rdt_pkg::ST_ADDR;
            bit_nxt = 3'h0;
            oe_nxt = 1'b0;
        end else begin
            case (st_r)
                rdt_pkg::ST_ADDR: begin
                    if (ev.rise) begin
                        sh_nxt = byte_in;
                        bit_nxt = bit_r + 3'h1;
                        if (bit_r == rdt_pkg::BIT_LAST) begin
                            st_nxt = (byte_in[7:1] == {DEV_CODE, rdt_pkg::TRIM_CMD}) ?
                                rdt_pkg::ST_ACKA : rdt_pkg::ST_IDLE;
                        end
                    end
                end
                rdt_pkg::ST_ACKA: begin
                    if (ev.fall) begin
                        if (!oe_r) begin
                            oe_nxt = 1'b1;
                        end else if (sh_r[0]) begin
                            oe_nxt = ~trim_r[7];
                            sh_nxt = trim_r;
                            bit_nxt = 3'h0;
                            st_nxt = rdt_pkg::ST_RDATA;
                        end else begin
                            oe_nxt = 1'b0;
                            bit_nxt = 3'h0;
                            st_nxt = rdt_pkg::ST_WDATA;
                        end
                    end
                end
                rdt_pkg::ST_WDATA: begin
                    if (ev.rise) begin
                        sh_nxt = byte_in;
                        bit_nxt = bit_r + 3'h1;
                        if (bit_r == rdt_pkg::BIT_LAST) begin
                            trim_nxt = byte_in;
                            st_nxt = rdt_pkg::ST_ACKW;
                        end
                    end
                end
                rdt_pkg::ST_ACKW: begin
                    if (ev.fall) begin
                        if (!oe_r) begin
                            oe_nxt = 1'b1;
                        end else begin
                            oe_nxt = 1'b0;
                            st_nxt = rdt_pkg::ST_WDATA;
                        end
                    end
                end
                rdt_pkg::ST_RDATA: begin
                    if (ev.rise) begin
                        bit_nxt = bit_r + 3'h1;
                        if (bit_r == rdt_pkg::BIT_LAST) begin
                            st_nxt = rdt_pkg::ST_RACK;
                        end
                    end else if (ev.fall) begin
                        sh_nxt = {sh_r[6:0], 1'b0};
                        oe_nxt = ~sh_r[6];
                    end
                end
                rdt_pkg::ST_RACK: begin
                    if (ev.fall) begin
                        oe_nxt = 1'b0;
                    end else if (ev.rise) begin
                        st_nxt = ev.sda ? rdt_pkg::ST_IDLE : rdt_pkg::ST_RNEXT;
                    end
                end
                rdt_pkg::ST_RNEXT: begin
                    if (ev.fall) begin
                        sh_nxt = trim_r;
                        oe_nxt = ~trim_r[7];
                        bit_nxt = 3'h0;
                        st_nxt = rdt_pkg::ST_RDATA;
                    end
                end
                default: begin
                    st_nxt = rdt_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Serial port registers
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            st_r <= rdt_pkg::ST_IDLE;
            bit_r <= 3'h0;
            sh_r <= 8'h00;
            oe_r <= 1'b0;
            trim_r <= rdt_pkg::TRIM_RESET;
        end else begin
            st_r <= st_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            oe_r <= oe_nxt;
            trim_r <= trim_nxt;
        end
    end

    // Divider chain state
    logic [15:0] cnt_r, cnt_nxt;
    logic [5:0] grp_r, grp_nxt;
    logic [7:0] act_r, act_nxt;
    logic tick_r, tick_nxt;
    logic hz1_r, hz1_nxt;
    logic clk32_r;
    logic [15:0] cur_len;
    logic [5:0] grp_size;

    // Divider with one trimmed period per group
    always_comb begin
        cnt_nxt = cnt_r;
        grp_nxt = grp_r;
        act_nxt = act_r;
        tick_nxt = 1'b0;
        cur_len = (grp_r == 6'h00) ? trim_len(act_r) : rdt_pkg::NOM_PERIOD;
        grp_size = act_r[0] ? rdt_pkg::GROUP_FINE : rdt_pkg::GROUP_COARSE;
        if (osc_rise) begin
            if (cnt_r == cur_len - 16'h0001) begin
                cnt_nxt = 16'h0000;
                tick_nxt = 1'b1;
                if (grp_r == grp_size - 6'h01) begin
                    grp_nxt = 6'h00;
                    act_nxt = trim_r;
                end else begin
                    grp_nxt = grp_r + 6'h01;
                end
            end else begin
                cnt_nxt = cnt_r + 16'h0001;
            end
        end
        hz1_nxt = (cnt_nxt < rdt_pkg::HALF_PERIOD);
    end

    // Divider registers; 32 kHz output follows the synchronised oscillator
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_r <= 16'h0000;
            grp_r <= 6'h00;
            act_r <= rdt_pkg::TRIM_RESET;
            tick_r <= 1'b0;
            hz1_r <= 1'b0;
            clk32_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            grp_r <= grp_nxt;
            act_r <= act_nxt;
            tick_r <= tick_nxt;
            hz1_r <= hz1_nxt;
            clk32_r <= s_q[0];
        end
    end

    assign sda_out = 1'b0; // Open drain: only the enable moves
    assign sda_oe = oe_r;
    assign clk32_out = clk32_r;
    assign sec_tick = tick_r;
    assign hz1_out = hz1_r;

    // Checks
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);

    // Step code of the live register, so every written nonzero code is checked without waiting a group
    logic [6:0] code_new;
    always_comb begin
        for (int i = 0; i < 7; i++) begin
            code_new[i] = trim_r[7-i];
        end
    end

    AST_GROUP_RANGE: assert property (grp_r < (act_r[0] ? 6'h3C : 6'h14))
        else $error("trim group index beyond group size");
    AST_NOMINAL: assert property (grp_r != 6'h00 |-> cur_len == 16'h8000)
        else $error("untrimmed period not nominal");
    AST_FAST: assert property (code_new != 7'h00 && code_new < 7'h40
        |-> trim_len(trim_r) == 16'h8000 - {8'h00, code_new, 1'b0})
        else $error("speed-up period length wrong");
    AST_SLOW: assert property (code_new >= 7'h40
        |-> trim_len(trim_r) == 16'h8000 + {7'h00, 8'h80 - {1'b0, code_new}, 1'b0})
        else $error("slow-down period length wrong");
    AST_ZERO: assert property (act_r[7:1] == 7'h00 |-> cur_len == 16'h8000)
        else $error("zero code altered period");
    AST_LATCH: assert property ($changed(act_r) |-> grp_r == 6'h00 && cnt_r == 16'h0000 && $past(tick_nxt))
        else $error("trim applied mid group");
    AST_CLK32: assert property (osc_rise |=> clk32_out)
        else $error("32 kHz output not following oscillator");
    AST_START: assert property (ev.start && !ev.stop |=> st_r == rdt_pkg::ST_ADDR && !sda_oe)
        else $error("start not detected");
    AST_STOP: assert property (ev.stop |=> st_r == rdt_pkg::ST_IDLE && !sda_oe)
        else $error("stop did not return to idle");
    AST_WRITE: assert property (st_r == rdt_pkg::ST_WDATA && ev.rise && bit_r == 3'h7 && !ev.start && !ev.stop
        |=> trim_r == $past(byte_in) ##1 (st_r == rdt_pkg::ST_ACKW || st_r == rdt_pkg::ST_IDLE
        || st_r == rdt_pkg::ST_ADDR))
        else $error("register write lost");

    CVR_WRITE: cover property (st_r == rdt_pkg::ST_ACKW && ev.fall && oe_r);
    CVR_READ: cover property (st_r == rdt_pkg::ST_RACK && ev.rise);
    CVR_COARSE_WRAP: cover property (tick_nxt && grp_r == 6'h13 && !act_r[0]);
    CVR_FINE_WRAP: cover property (tick_nxt && grp_r == 6'h3B && act_r[0]);
endmodule : rdt_trim
`default_nettype wire

// ===== verif/rdt_trim_test.sv
// Self-checking bench for the rate-trim block: serial register access and timebase.
// Assumes an open-drain data pin with a pull-up and a free-running oscillator pin.
`timescale 1ns/1ns
`default_nettype none
module rdt_trim_test;
    localparam logic [3:0] DEV = 4'h9; // Arbitrary device code value
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic scl = 1'b1;
    logic m_sda = 1'b1;
    logic osc = 1'b0;
    logic [1:0] osc_div = 2'h0;
    logic clk32_d = 1'b0;
    logic sda_out, sda_oe, clk32_out, sec_tick, hz1_out;
    logic [7:0] corners [4] = '{8'hFF, 8'h7C, 8'h02, 8'h66};
    wire sda_w;
    int bad_count = 0;
    int checked = 0;
    int osc_rises = 0;
    int clk_rises = 0;
    int sec_cnt = 0;
    int seed = 32'h52b8;

    // Pin level: pulled high unless either party pulls it low
    assign sda_w = m_sda & ~sda_oe;

    rdt_trim #(.DEV_CODE(DEV)) rdt_trim_i (.clock(clock), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_w),
        .osc_in(osc), .sda_out(sda_out), .sda_oe(sda_oe), .clk32_out(clk32_out), .sec_tick(sec_tick),
        .hz1_out(hz1_out));

    // Clock
    always #2 clock = ~clock;

    // Oscillator at a quarter of the clock rate; edge counts since reset
    always @(posedge clock) begin
        osc_div <= osc_div + 2'h1;
        osc <= osc_div[1];
        clk32_d <= clk32_out;
        if (!arst_n) begin
            osc_rises <= 0;
            clk_rises <= 0;
            sec_cnt <= 0;
        end else begin
            if (osc_div == 2'h2 && !osc) osc_rises <= osc_rises + 1;
            if (clk32_out && !clk32_d) clk_rises <= clk_rises + 1;
            if (sec_tick) sec_cnt <= sec_cnt + 1;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
    endtask : tick

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            bad_count++;
        end
    endtask : chk

    task automatic chk_rng(input string what, input int lo, input int hi, input int got);
        checked++;
        if (got < lo || got > hi) begin
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
            bad_count++;
        end
    endtask : chk_rng

    function automatic logic [7:0] addr_byte(input logic rw);
        return {DEV, 3'h3, rw};
    endfunction : addr_byte

    // Software never writes speed-up code 63; such a draw becomes code 127 instead
    function automatic logic [7:0] legal_trim(input logic [7:0] t);
        return (t[7:1] == 7'h7E) ? {7'h7F, t[0]} : t;
    endfunction : legal_trim

    // One clock pulse; data set while the serial clock is low, pin sampled late in the high phase
    task automatic bit_io(input logic b, output logic seen);
        m_sda <= b;
        tick(6);
        scl <= 1'b1;
        tick(10);
        seen = sda_w;
        scl <= 1'b0;
        tick(6);
    endtask : bit_io

    task automatic start_c;
        m_sda <= 1'b1;
        tick(6);
        scl <= 1'b1;
        tick(10);
        m_sda <= 1'b0;
        tick(10);
        scl <= 1'b0;
        tick(6);
    endtask : start_c

    task automatic stop_c;
        m_sda <= 1'b0;
        tick(6);
        scl <= 1'b1;
        tick(10);
        m_sda <= 1'b1;
        tick(10);
    endtask : stop_c

    task automatic send_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(v[i], s);
        bit_io(1'b1, ack);
    endtask : send_byte

    task automatic recv_byte(input logic nack, output logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, s);
            v[i] = s;
        end
        bit_io(nack, s);
    endtask : recv_byte

    task automatic wr(input logic [7:0] v);
        logic k;
        start_c;
        send_byte(addr_byte(1'b0), k);
        chk("address ack", 8'h00, {7'h00, k});
        send_byte(v, k);
        chk("data ack", 8'h00, {7'h00, k});
        stop_c;
        chk("released after stop", 8'h00, {7'h00, sda_oe});
        chk("drive level", 8'h00, {7'h00, sda_out});
    endtask : wr

    task automatic rd(input logic [7:0] exp);
        logic k;
        logic [7:0] v;
        start_c;
        send_byte(addr_byte(1'b1), k);
        recv_byte(1'b1, v);
        stop_c;
        chk("trim readback", exp, v);
    endtask : rd

    task automatic final_report;
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : final_report

    // Watchdog against a hung sequence
    initial begin
        tick(90000);
        bad_count++;
        final_report;
    end

    // Main sequence
    initial begin
        logic k;
        logic [7:0] v, v2, cur;
        tick(2);
        arst_n <= 1'b1;
        tick(4);
        rd(8'h00);
        chk("half period level", 8'h01, {7'h00, hz1_out});
        // Corner then random trim values, written and read back
        for (int i = 0; i < 10; i++) begin
            cur = (i < 4) ? corners[i] : legal_trim(8'($random(seed)));
            wr(cur);
            rd(cur);
        end
        // Two bytes in one write, last wins; an acknowledged read repeats the byte
        start_c;
        send_byte(addr_byte(1'b0), k);
        send_byte(8'hA5, k);
        send_byte(8'h3C, k);
        stop_c;
        start_c;
        send_byte(addr_byte(1'b1), k);
        recv_byte(1'b0, v);
        recv_byte(1'b1, v2);
        stop_c;
        chk("first read byte", 8'h3C, v);
        chk("repeated read byte", 8'h3C, v2);
        // Foreign device code gets no acknowledge and writes nothing
        start_c;
        send_byte({~DEV, 3'h3, 1'b0}, k);
        chk("foreign ack", 8'h01, {7'h00, k});
        send_byte(8'h11, k);
        stop_c;
        // Bytes without a start are ignored
        scl <= 1'b0;
        tick(6);
        send_byte(addr_byte(1'b0), k);
        chk("ack without start", 8'h01, {7'h00, k});
        send_byte(8'h22, k);
        stop_c;
        rd(8'h3C);
        // Stop in mid byte aborts the write
        start_c;
        send_byte(addr_byte(1'b0), k);
        for (int i = 0; i < 4; i++) bit_io(1'b0, k);
        stop_c;
        rd(8'h3C);
        // First half period nominal; oscillator copy untouched by the trim
        for (int n = 0; n < 70000 && hz1_out !== 1'b0; n++) tick(1);
        chk_rng("oscillator ticks at half period", 16383, 16385, osc_rises);
        chk_rng("oscillator copy edges", osc_rises - 1, osc_rises + 1, clk_rises);
        chk_rng("seconds before half period", 0, 0, sec_cnt);
        chk("second tick idle", 8'h00, {7'h00, sec_tick});
        final_report;
    end
endmodule : rdt_trim_test
`default_nettype wire
